// ==== logic/acp_controller.sv ====
// Controller end: result FIFO and the select, clock and word sequencer
`timescale 1ns/10ps
`default_nettype none
`include "acp_defs.svh"

// Result buffer with a registered output stage
module acp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage words
  logic [AW-1:0]    wr_ptr;        // Next write slot
  logic [AW-1:0]    rd_ptr;        // Next read slot
  logic [AW:0]      count;         // Words held in storage

  // Accept while not full; move a word out when the stage is free
  assign in_ready = (count != (AW+1)'(DEPTH));
  wire push = in_valid & in_ready;
  wire pop  = (count != '0) & (~out_valid | out_ready);

  // Storage write
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers, fill count and output stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr    <= rd_ptr + AW'(1);
        out_data  <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// Sequencer: one command is one frame plus one conversion
module acp_controller #(
  parameter int WAKE_CYC = `ACP_WAKE_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  acp_link_if.host                link,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire acp_pkg::acp_word_t cmd_word,
  input  wire logic               nap_mode,
  output logic                    res_valid,
  input  wire logic               res_ready,
  output acp_pkg::acp_data_t      res_data,
  output logic                    dev_asleep,
  output logic                    waking
);

  acp_pkg::acp_host_state_t state;       // Sequencer state
  acp_pkg::acp_host_state_t next_state;  // State for the next edge
  logic [23:0]        tmr;               // Time since the start edge or phase
  logic [4:0]         div;               // Serial clock divider
  logic [4:0]         nbit;              // Bits clocked this frame
  acp_pkg::acp_data_t tx_sr;             // Outgoing word, left aligned
  acp_pkg::acp_data_t rx_sr;             // Incoming result
  logic               nap_lat;           // Nap mode of this command
  logic               wake_pend;         // This conversion follows a release
  logic               sdo_s1;            // First sync stage
  logic               sdo_s2;            // Second sync stage
  logic               push;              // Result into the buffer
  logic               fifo_rdy;          // Buffer has room

  wire take     = cmd_valid & cmd_ready;
  wire half     = (div == 5'(`ACP_SCK_HALF_CYC - 1));
  wire sck_up   = (state == acp_pkg::ACP_HS_SHIFT) & half & ~link.sck;
  wire sck_dn   = (state == acp_pkg::ACP_HS_SHIFT) & half & link.sck;
  wire last_dn  = sck_dn & (nbit == 5'(`ACP_DATA_BITS));
  wire pulse_end = (tmr == 24'(`ACP_PULSE_CYC - 1));
  wire conv_end  = (tmr == 24'(`ACP_CONV_WAIT_CYC - 1));
  wire acq_end   = (tmr == 24'(`ACP_ACQ_CYC - 1));
  wire wake_end  = (tmr == 24'(WAKE_CYC - 1));

  acp_fifo #(.WIDTH(`ACP_DATA_BITS), .DEPTH(16)) i_acp_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (rx_sr),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  // Sequence of one command
  always_comb begin
    next_state = state;
    case (state)
      acp_pkg::ACP_HS_IDLE:  if (take) next_state = acp_pkg::ACP_HS_SHIFT;
      acp_pkg::ACP_HS_SHIFT: begin
        // Frame ends with the start edge; nap mode keeps select high
        if (last_dn) begin
          next_state = nap_lat ? acp_pkg::ACP_HS_CONV : acp_pkg::ACP_HS_PULSE;
        end
      end
      acp_pkg::ACP_HS_PULSE: if (pulse_end) next_state = acp_pkg::ACP_HS_CONV;
      acp_pkg::ACP_HS_CONV: begin
        // Wait the worst conversion time before touching the bus
        if (conv_end) begin
          next_state = wake_pend ? acp_pkg::ACP_HS_WAKE : acp_pkg::ACP_HS_ACQ;
        end
      end
      acp_pkg::ACP_HS_WAKE:  if (wake_end) next_state = acp_pkg::ACP_HS_ACQ;
      acp_pkg::ACP_HS_ACQ:   if (acq_end) next_state = acp_pkg::ACP_HS_IDLE;
      default:               next_state = acp_pkg::ACP_HS_IDLE;
    endcase
  end

  // Phase timer restarts at each state change except into CONV, where it runs on from the start edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= acp_pkg::ACP_HS_IDLE;
      tmr   <= 24'h000000;
    end else begin
      state <= next_state;
      if (next_state != state && next_state != acp_pkg::ACP_HS_CONV) begin
        tmr <= 24'h000000;
      end else if (state == acp_pkg::ACP_HS_SHIFT) begin
        tmr <= 24'h000000;
      end else begin
        tmr <= tmr + 24'h000001;
      end
    end
  end

  // Result line synchroniser
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sdo_s1 <= 1'b1;
      sdo_s2 <= 1'b1;
    end else begin
      sdo_s1 <= link.sdo;
      sdo_s2 <= sdo_s1;
    end
  end

  // Serial frame: change on falling clock, sample on rising clock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div      <= 5'h00;
      nbit     <= 5'h00;
      tx_sr    <= 16'h0000;
      rx_sr    <= 16'h0000;
      link.sck <= 1'b0;
      link.sdi <= 1'b0;
    end else if (take) begin
      div      <= 5'h00;
      nbit     <= 5'h00;
      tx_sr    <= {cmd_word[5:0], 10'h000};
      link.sdi <= cmd_word[6];
    end else if (state == acp_pkg::ACP_HS_SHIFT) begin
      div <= half ? 5'h00 : div + 5'h01;
      if (half) begin
        link.sck <= ~link.sck;
      end
      if (sck_up) begin
        rx_sr <= {rx_sr[14:0], sdo_s2};
        nbit  <= nbit + 5'h01;
      end
      if (sck_dn) begin
        link.sdi <= tx_sr[15];
        tx_sr    <= {tx_sr[14:0], 1'b0};
      end
    end else begin
      // Clock and data stay low outside the frame
      link.sck <= 1'b0;
      link.sdi <= 1'b0;
    end
  end

  // Select, command handshake and sleep tracking
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      link.sel_conv <= 1'b0;
      cmd_ready     <= 1'b0;
      nap_lat       <= 1'b0;
      wake_pend     <= 1'b0;
      dev_asleep    <= 1'b0;
      waking        <= 1'b0;
      push          <= 1'b0;
    end else begin
      push      <= last_dn & fifo_rdy;
      cmd_ready <= (next_state == acp_pkg::ACP_HS_IDLE) & fifo_rdy & ~take;
      waking    <= (next_state == acp_pkg::ACP_HS_WAKE);
      if (take) begin
        nap_lat    <= nap_mode;
        wake_pend  <= dev_asleep & ~cmd_word[`ACP_BIT_SLEEP];
        dev_asleep <= cmd_word[`ACP_BIT_SLEEP];
      end
      if (last_dn) begin
        link.sel_conv <= 1'b1;
      end else if (pulse_end && state == acp_pkg::ACP_HS_PULSE) begin
        link.sel_conv <= 1'b0;
      end else if (conv_end && state == acp_pkg::ACP_HS_CONV) begin
        link.sel_conv <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ==== logic/acp_defs.svh ====
// Shared constants of the converter link: timing counts, word layout, reset values
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

// System clock period in ns (250 MHz)
`define ACP_CLK_NS          4
// Conversion time, typical and worst case, in ns
`define ACP_T_CONV_TYP_NS   3000
`define ACP_T_CONV_MAX_NS   3500
// Acquisition time in ns
`define ACP_T_ACQ_NS        1100
// Latest return of select after a start edge, in ns
`define ACP_T_PULSE_NS      100
// Wake-up time after release from sleep, in ms
`define ACP_T_WAKE_MS       60
// Cycles the converter spends converting (typical, exact)
`define ACP_CONV_CYC        (`ACP_T_CONV_TYP_NS / `ACP_CLK_NS)
// Least wait for a result on the controller side, rounded up
`define ACP_CONV_WAIT_CYC   ((`ACP_T_CONV_MAX_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
// Least acquisition wait, rounded up
`define ACP_ACQ_CYC         ((`ACP_T_ACQ_NS + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
// Longest select pulse, rounded down
`define ACP_PULSE_CYC       (`ACP_T_PULSE_NS / `ACP_CLK_NS)
// Least wake wait, rounded up
`define ACP_WAKE_CYC        ((`ACP_T_WAKE_MS * 1000000 + `ACP_CLK_NS - 1) / `ACP_CLK_NS)
// Half period of the serial clock made by the controller, in cycles
`define ACP_SCK_HALF_CYC    16
// Serial word layout: 7 bits sent MSB first
`define ACP_WORD_BITS       7
`define ACP_DATA_BITS       16
`define ACP_BIT_SLEEP       0
`define ACP_BIT_UNIPOLAR    1
`define ACP_CFG_LSB         2
`define ACP_CFG_BITS        5
// Reset value of the applied word: bipolar, awake, mux code zero
`define ACP_WORD_RST        7'h00

`endif

// ==== logic/acp_pkg.sv ====
// Types shared by both ends of the converter link
package acp_pkg;

  // Result word and serial input word
  typedef logic [15:0] acp_data_t;
  typedef logic [6:0]  acp_word_t;

  // Converter power and conversion states, one-hot
  typedef enum logic [3:0] {
    ACP_DS_ACQ   = 4'h1,
    ACP_DS_CONV  = 4'h2,
    ACP_DS_NAP   = 4'h4,
    ACP_DS_SLEEP = 4'h8
  } acp_dev_state_t;

  // Controller sequence states, one-hot
  typedef enum logic [5:0] {
    ACP_HS_IDLE  = 6'h01,
    ACP_HS_SHIFT = 6'h02,
    ACP_HS_PULSE = 6'h04,
    ACP_HS_CONV  = 6'h08,
    ACP_HS_WAKE  = 6'h10,
    ACP_HS_ACQ   = 6'h20
  } acp_host_state_t;

endpackage

// ==== logic/acp_link_if.sv ====
// Serial link between controller and converter
`timescale 1ns/10ps
`default_nettype none

interface acp_link_if;
  logic sel_conv;   // Select/convert, rising edge starts a conversion
  logic sck;        // Serial clock from the controller
  logic sdi;        // Serial data to the converter
  logic sdo_o;      // Converter output value
  logic sdo_oe;     // Converter drives sdo while high
  wire  sdo;        // Resolved line, pulled high when undriven

  assign sdo = sdo_oe ? sdo_o : 1'b1;

  modport dev  (input sel_conv, input sck, input sdi, output sdo_o, output sdo_oe);
  modport host (output sel_conv, output sck, output sdi, input sdo);
endinterface

`default_nettype wire

// ==== logic/acp_converter.sv ====
// Converter end: start edges, conversion timing, nap and sleep, serial result port
`timescale 1ns/10ps
`default_nettype none
`include "acp_defs.svh"

module acp_converter (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  acp_link_if.dev                link,
  input  wire acp_pkg::acp_data_t sample_code,
  output logic                   conv_start,
  output logic                   conv_busy,
  output logic                   nap_active,
  output logic                   sleep_active,
  output logic                   cfg_valid,
  output logic [4:0]             mux_cfg
);

  // Straight binary for unipolar, two's complement for bipolar
  function automatic acp_pkg::acp_data_t acp_format(
    input acp_pkg::acp_data_t code,
    input logic               unipolar
  );
    acp_format = unipolar ? code : {~code[15], code[14:0]};
  endfunction

  // Pin synchronisers: bit 2 select, bit 1 clock, bit 0 data
  logic [2:0]              pin_s1;       // First stage, read by stage two only
  logic [2:0]              pin_s2;       // Second stage, safe to use
  logic [1:0]              pin_s3;       // Delayed copy for edge finding
  // Conversion state and counters
  acp_pkg::acp_dev_state_t state;        // Power and conversion state
  acp_pkg::acp_dev_state_t next_state;   // State for the next edge
  logic [9:0]              conv_cnt;     // Cycles spent converting
  // Serial data path
  acp_pkg::acp_data_t      dout_sr;      // Result shift register
  acp_pkg::acp_data_t      next_dout;    // Next result shift value
  acp_pkg::acp_data_t      samp;         // Sample held since start
  acp_pkg::acp_word_t      word_sr;      // Incoming word shift register
  acp_pkg::acp_word_t      cur_word;     // Word now in effect
  logic [2:0]              bit_cnt;      // Word bits received, saturating

  // Decoded events
  wire sel_lvl   = pin_s2[2];
  wire sel_rise  = pin_s2[2] & ~pin_s3[1];
  wire sck_rise  = pin_s2[1] & ~pin_s3[0];
  wire sck_fall  = ~pin_s2[1] & pin_s3[0];
  wire sdi_lvl   = pin_s2[0];
  wire in_conv   = (state == acp_pkg::ACP_DS_CONV);
  // Serial port is live only with select low and no conversion running
  wire port_en   = ~sel_lvl & ~in_conv;
  wire word_full = (bit_cnt == 3'(`ACP_WORD_BITS));
  // A complete word replaces the word in effect at the start edge
  wire acp_pkg::acp_word_t eff_word = word_full ? word_sr : cur_word;
  wire sleep_req = eff_word[`ACP_BIT_SLEEP];
  wire conv_done = in_conv & (conv_cnt == 10'(`ACP_CONV_CYC - 1));
  // Start edges count only outside a conversion
  wire start_ok  = sel_rise & ~in_conv;
  wire do_conv   = start_ok & ~sleep_req;

  // Two flip-flops on every pin before use, a third for edges
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 2'h0;
    end else begin
      pin_s1 <= {link.sel_conv, link.sck, link.sdi};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2[2:1];
    end
  end

  // Next state of the power sequence
  always_comb begin
    next_state = state;
    case (state)
      acp_pkg::ACP_DS_ACQ: begin
        // Powered and acquiring; a start edge converts or sleeps
        if (start_ok) begin
          next_state = sleep_req ? acp_pkg::ACP_DS_SLEEP
                                 : acp_pkg::ACP_DS_CONV;
        end
      end
      acp_pkg::ACP_DS_CONV: begin
        // Further start edges ignored until the count runs out
        if (conv_done) begin
          next_state = sel_lvl ? acp_pkg::ACP_DS_NAP
                               : acp_pkg::ACP_DS_ACQ;
        end
      end
      acp_pkg::ACP_DS_NAP: begin
        // Napping; a start edge converts or sleeps, select low powers up
        if (start_ok) begin
          next_state = sleep_req ? acp_pkg::ACP_DS_SLEEP
                                 : acp_pkg::ACP_DS_CONV;
        end else if (!sel_lvl) begin
          next_state = acp_pkg::ACP_DS_ACQ;
        end
      end
      acp_pkg::ACP_DS_SLEEP: begin
        // Only a complete word with the sleep bit clear wakes it
        if (start_ok && word_full && !sleep_req) begin
          next_state = acp_pkg::ACP_DS_CONV;
        end
      end
      default: begin
        next_state = acp_pkg::ACP_DS_ACQ;
      end
    endcase
  end

  // Sleep start edges only convert when a wake word arrived
  wire start_now = (next_state == acp_pkg::ACP_DS_CONV) & ~in_conv;

  // State register and conversion counter
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state    <= acp_pkg::ACP_DS_ACQ;
      conv_cnt <= 10'h000;
    end else begin
      state    <= next_state;
      // Count restarts at each accepted start edge
      if (start_now) begin
        conv_cnt <= 10'h000;
      end else if (in_conv) begin
        conv_cnt <= conv_cnt + 10'h001;
      end
    end
  end

  // Sample taken at the start edge, as the track-and-hold would
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      samp <= 16'h0000;
    end else if (start_now) begin
      samp <= sample_code;
    end
  end

  // Result shifter: load at conversion end, shift on falling clock
  always_comb begin
    next_dout = dout_sr;
    if (conv_done) begin
      next_dout = acp_format(samp, cur_word[`ACP_BIT_UNIPOLAR]);
    end else if (port_en && sck_fall) begin
      next_dout = {dout_sr[14:0], 1'b0};
    end
  end

  // Result register and output pin, driven while select is low and no conversion runs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dout_sr     <= 16'h0000;
      link.sdo_o  <= 1'b0;
      link.sdo_oe <= 1'b0;
    end else begin
      dout_sr     <= next_dout;
      // MSB appears at conversion end when select is already low
      link.sdo_o  <= next_dout[15];
      link.sdo_oe <= ~sel_lvl & (next_state != acp_pkg::ACP_DS_CONV);
    end
  end

  // Incoming word: sampled on rising clock, applied at the start edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      word_sr  <= 7'h00;
      bit_cnt  <= 3'h0;
      cur_word <= `ACP_WORD_RST;
    end else begin
      if (start_ok) begin
        // A new frame begins after every accepted edge
        bit_cnt  <= 3'h0;
        cur_word <= eff_word;
      end else if (port_en && sck_rise && !word_full) begin
        // Clock and data are only looked at while the port is live;
        // the first seven bits form the word, later bits are dropped
        word_sr  <= {word_sr[5:0], sdi_lvl};
        bit_cnt  <= bit_cnt + 3'h1;
      end
    end
  end

  // Status outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv_start   <= 1'b0;
      conv_busy    <= 1'b0;
      nap_active   <= 1'b0;
      sleep_active <= 1'b0;
      cfg_valid    <= 1'b0;
      mux_cfg      <= 5'(`ACP_WORD_RST >> `ACP_CFG_LSB);
    end else begin
      conv_start   <= start_now;
      conv_busy    <= (next_state == acp_pkg::ACP_DS_CONV);
      // Only the references stay up in nap
      nap_active   <= (next_state == acp_pkg::ACP_DS_NAP);
      sleep_active <= (next_state == acp_pkg::ACP_DS_SLEEP);
      cfg_valid    <= start_ok & word_full;
      if (start_ok && word_full) begin
        mux_cfg <= word_sr[`ACP_WORD_BITS-1:`ACP_CFG_LSB];
      end
    end
  end

endmodule

`default_nettype wire

// ==== verif/acp_link_asserts.sv ====
// Checker of the link between controller and converter
`timescale 1ns/10ps
`default_nettype none
`include "acp_defs.svh"

module acp_link_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sel_conv,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_oe,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic nap_active,
  input wire logic sleep_active
);
  localparam int CONV_CYC  = `ACP_CONV_CYC;   // Exact conversion length
  localparam int PULSE_CYC = `ACP_PULSE_CYC;  // Longest short select pulse
  localparam int GAP_CYC   = 1150;            // Least spacing of start edges
  logic [11:0] busy_cnt;  // Cycles spent converting so far
  logic [11:0] hi_cnt;    // Cycles select has stayed high
  logic [11:0] gap_cnt;   // Cycles since the last start edge, saturating
  logic        sel_q;     // Select one cycle ago
  wire         sel_rise = sel_conv && !sel_q;  // Start edge on the pin

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Busy and select-high lengths
  always_ff @(posedge sys_clk) begin
    busy_cnt <= conv_busy ? busy_cnt + 12'h001 : 12'h000;
    hi_cnt   <= sel_conv ? hi_cnt + 12'h001 : 12'h000;
  end

  // Spacing between start edges, held at its top after reset
  always_ff @(posedge sys_clk) begin
    sel_q   <= sel_conv;
    gap_cnt <= sys_rst ? 12'hFFF : sel_rise ? 12'h001 :
               (gap_cnt == 12'hFFF) ? 12'hFFF : gap_cnt + 12'h001;
  end

  property p_start;
    $rose(sel_conv) && !conv_busy |-> ##[1:4] (conv_start || sleep_active);
  endproperty
  a_start: assert property (p_start) else $error("start edge not taken");

  property p_no_restart;
    conv_busy && $past(conv_busy) |-> !conv_start;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart in conversion");

  property p_conv_len;
    $fell(conv_busy) |-> busy_cnt == CONV_CYC;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_gap;
    $rose(sel_conv) |-> gap_cnt >= GAP_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("start edges too close");

  property p_nap;
    $fell(conv_busy) && sel_conv |-> ##[0:2] nap_active;
  endproperty
  a_nap: assert property (p_nap) else $error("no nap with select high");

  property p_msb;
    $fell(conv_busy) && !sel_conv |-> ##[0:2] (sdo_oe && !nap_active);
  endproperty
  a_msb: assert property (p_msb) else $error("serial output not driven");

  property p_pulse;
    $fell(sel_conv) |-> hi_cnt <= PULSE_CYC || hi_cnt >= CONV_CYC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("select dropped mid conversion");

  property p_quiet;
    conv_busy |-> $stable(sck) && $stable(sdi);
  endproperty
  a_quiet: assert property (p_quiet) else $error("serial lines moved");

  property p_oe_off;
    conv_busy && $past(conv_busy, 2) |-> !sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven in conversion");

  // Main scenarios seen
  c_nap:   cover property ($fell(conv_busy) && sel_conv);
  c_msb:   cover property ($fell(conv_busy) && !sel_conv);
  c_sleep: cover property ($rose(sleep_active));
endmodule

`default_nettype wire

// ==== verif/tb.sv ====
// Bench joining controller and converter through the link
`timescale 1ns/10ps
`default_nettype none
`include "acp_defs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tb;
  localparam int WAKE = 200;                // Shortened wake wait
  logic               sys_clk, sys_rst;     // Clock and reset
  logic               cmd_valid, cmd_ready; // Command handshake
  logic               nap_mode;             // Select held through conversion
  logic               res_valid, res_ready; // Result handshake
  acp_pkg::acp_word_t cmd_word;             // Word to send
  acp_pkg::acp_data_t sample_code;          // Analog stand-in
  acp_pkg::acp_data_t res_data, got;        // Result seen
  acp_pkg::acp_data_t exp_q[$];             // Expected results in order
  logic               conv_start, conv_busy, nap_active, sleep_active;
  logic               cfg_valid, dev_asleep, waking, busy_q, oe_end;
  logic [4:0]         mux_cfg, mux_seen;    // Applied mux field
  int                 failures, tests_run, starts, exp_starts, waked, n, naps;

  acp_link_if i_acp_link_if ();
  acp_converter i_acp_converter (.sys_clk, .sys_rst, .link(i_acp_link_if), .sample_code,
    .conv_start, .conv_busy, .nap_active, .sleep_active, .cfg_valid, .mux_cfg);
  acp_controller #(.WAKE_CYC(WAKE)) i_acp_controller (.sys_clk, .sys_rst,
    .link(i_acp_link_if), .cmd_valid, .cmd_ready, .cmd_word, .nap_mode, .res_valid,
    .res_ready, .res_data, .dev_asleep, .waking);
  acp_link_asserts i_acp_link_asserts (.sys_clk, .sys_rst,
    .sel_conv(i_acp_link_if.sel_conv), .sck(i_acp_link_if.sck), .sdi(i_acp_link_if.sdi),
    .sdo_oe(i_acp_link_if.sdo_oe), .conv_start, .conv_busy, .nap_active, .sleep_active);

  // Clock of 4 ns
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Count start pulses and wake cycles, keep the last applied mux field
  always @(posedge sys_clk) begin
    if (conv_start === 1'b1) starts++;
    if (waking === 1'b1) waked++;
    if (nap_active === 1'b1) naps++;
    // Output enable one cycle after the conversion end
    if (busy_q === 1'b1 && conv_busy === 1'b0) oe_end = i_acp_link_if.sdo_oe;
    busy_q = conv_busy;
    if (cfg_valid === 1'b1) mux_seen <= mux_cfg;
  end

  // Step to just after the next rising edge
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  // Offer one command, wait for its sequence to end, check the state left
  task automatic send(input acp_pkg::acp_word_t w, input logic nap,
                      input acp_pkg::acp_data_t s, input logic rdy);
    sample_code = s;
    naps = 0;
    cmd_word = w;
    nap_mode = nap;
    cmd_valid = 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (cmd_ready !== 1'b1 && n < 3000);
    #1 cmd_valid = 1'b0;
    n = 0;
    do begin tick(); n++; end while (cmd_ready !== 1'b1 && n < 3000);
    `CHK("cmd_ready", rdy, cmd_ready)
    if (!w[0]) begin
      exp_starts++;
      exp_q.push_back(w[1] ? s : {~s[15], s[14:0]});
      `CHK("starts", exp_starts, starts)
      `CHK("nap", nap, naps > 0)
      `CHK("sdo_oe", !nap, oe_end)
      `CHK("mux", w[6:2], mux_seen)
    end
  endtask

  // Closing verdict
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(60000 * 4);
    failures++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {sys_rst, cmd_valid, res_ready, nap_mode, cmd_word, sample_code} = '0;
    sys_rst = 1'b1;
    repeat (10) tick();
    sys_rst = 1'b0;
    repeat (2) tick();
    // Fill the result buffer with reads stalled, both select styles and both modes
    for (int i = 0; i < 17; i++) begin
      send({5'(i), i[1], 1'b0}, i[0], 16'(i * 16'h1357 + 16'h8001), i < 16);
    end
    `CHK("full_refuse", 1'b0, cmd_ready)
    // Drain; the first word is stale, the rest follow the commands in order
    res_ready = 1'b1;
    for (int i = 0; i < 17; i++) begin
      n = 0;
      do begin @(posedge sys_clk); n++; end while (res_valid !== 1'b1 && n < 100);
      got = res_data;
      if (i > 0) `CHK("res_data", exp_q.pop_front(), got)
    end
    repeat (4) tick();
    `CHK("empty", 1'b0, res_valid)
    exp_q.delete();
    // Sleep request, then wake with a normal word
    send(7'h01, 1'b0, 16'h0F0F, 1'b1);
    `CHK("sleep", 1'b1, sleep_active)
    `CHK("asleep", 1'b1, dev_asleep)
    `CHK("no_start", exp_starts, starts)
    waked = 0;
    send(7'h28, 1'b1, 16'h00F0, 1'b1);
    `CHK("wake_wait", 1'b1, waked >= WAKE)
    `CHK("awake", 1'b0, sleep_active)
    `CHK("not_asleep", 1'b0, dev_asleep)
    wrap_up();
  end
endmodule

`default_nettype wire
